// ===== spg_guard.v
`timescale 1ns/100ps
`include "spg_regs.vh"
module spg_guard #(
    parameter ADDR_X8 = 9,
    parameter PROG_CYCLES = `SPG_PROG_TIME_NS / `SPG_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire sys_clk_in,
    input wire rst_n_in,
    // Serial link from the host
    input wire sel_in,
    input wire link_clk_in,
    input wire data_in,
    input wire org_x16_in,
    // Serial output
    output reg data_out,
    output reg data_oe_out,
    // Array state
    output reg busy_out,
    output reg write_enabled_out
);
    localparam ADDR_X16 = ADDR_X8 - 1;
    localparam WORDS = 1 << ADDR_X16;
    localparam LEN_X8 = `SPG_START_BITS + `SPG_OPCODE_BITS + ADDR_X8;
    localparam LEN_X16 = `SPG_START_BITS + `SPG_OPCODE_BITS + ADDR_X16;
    localparam CW = 6;
    localparam TW = 32;
    localparam SR = 27;
    localparam DL_X8 = `SPG_DATA_X8;
    localparam DL_X16 = `SPG_DATA_X16;

    localparam ST_IDLE = 2'd0;
    localparam ST_SHIFT = 2'd1;
    localparam ST_PROG = 2'd2;
    localparam ST_READY = 2'd3;

    wire sel_s;
    wire clk_s;
    wire din_s;
    wire org_s;
    reg clk_d;
    reg sel_d;
    reg [1:0] state;
    reg [CW-1:0] pulses;
    reg [SR-1:0] shreg;
    reg [TW-1:0] timer;
    reg [15:0] mem [0:WORDS-1];
    reg [1:0] pend_op;
    reg pend_all;
    reg [ADDR_X16-1:0] pend_addr;
    reg [15:0] pend_data;
    reg pend_lo;
    reg pend_hi;
    integer i;
    integer j;

    spg_sync #(.WIDTH(4)) u_sync (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .async_in({sel_in, link_clk_in, data_in, org_x16_in}),
        .sync_out({sel_s, clk_s, din_s, org_s})
    );

    wire rise = clk_s & ~clk_d;
    wire sel_fall = sel_d & ~sel_s;

    // Decode of the shifted frame, counted from the start bit
    wire [CW-1:0] hdr_len = org_s ? LEN_X16[CW-1:0] : LEN_X8[CW-1:0];
    wire [CW-1:0] dat_len = org_s ? DL_X16[CW-1:0] : DL_X8[CW-1:0];
    wire [SR-1:0] hdr = (pulses >= hdr_len) ? (shreg >> (pulses - hdr_len)) : {SR{1'b0}};
    wire [1:0] op = org_s ? hdr[ADDR_X16+1:ADDR_X16] : hdr[ADDR_X8+1:ADDR_X8];
    wire [1:0] sub = org_s ? hdr[ADDR_X16-1:ADDR_X16-2] : hdr[ADDR_X8-1:ADDR_X8-2];
    wire [ADDR_X8-1:0] addr = org_s ? {1'b0, hdr[ADDR_X16-1:0]} : hdr[ADDR_X8-1:0];
    wire has_data = (op == `SPG_OP_WRITE) || (op == `SPG_OP_SPECIAL && sub == `SPG_SUB_FILL);
    wire [CW-1:0] need = has_data ? hdr_len + dat_len : hdr_len;
    wire len_ok = (pulses == need);
    wire is_prog = (op == `SPG_OP_WRITE) || (op == `SPG_OP_ERASE) ||
        (op == `SPG_OP_SPECIAL && (sub == `SPG_SUB_FILL || sub == `SPG_SUB_CLEAR));
    wire [15:0] wdata = org_s ? shreg[15:0] : {8'hff, shreg[7:0]};

    always @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            clk_d <= 1'b0;
            sel_d <= 1'b0;
            state <= ST_IDLE;
            pulses <= {CW{1'b0}};
            shreg <= {SR{1'b0}};
            timer <= {TW{1'b0}};
            pend_op <= 2'b00;
            pend_all <= 1'b0;
            pend_addr <= {ADDR_X16{1'b0}};
            pend_data <= 16'hffff;
            pend_lo <= 1'b0;
            pend_hi <= 1'b0;
            data_out <= 1'b0;
            data_oe_out <= 1'b0;
            busy_out <= 1'b0;
            write_enabled_out <= 1'b0;
        end
        else
        begin
            clk_d <= clk_s;
            sel_d <= sel_s;
            case (state)
                ST_IDLE:
                begin
                    data_oe_out <= 1'b0;
                    pulses <= {CW{1'b0}};
                    if (sel_s && rise && din_s)
                    begin
                        state <= ST_SHIFT;
                        pulses <= {{(CW-1){1'b0}}, 1'b1};
                        shreg <= {SR{1'b0}};
                    end
                end
                ST_SHIFT:
                begin
                    if (rise && pulses != {CW{1'b1}})
                    begin
                        pulses <= pulses + 1'b1;
                        shreg <= {shreg[SR-2:0], din_s};
                    end
                    if (sel_fall)
                    begin
                        state <= ST_IDLE;
                        if (op == `SPG_OP_SPECIAL && sub == `SPG_SUB_ENABLE && pulses == hdr_len)
                            write_enabled_out <= 1'b1;
                        else if (op == `SPG_OP_SPECIAL && sub == `SPG_SUB_DISABLE && pulses == hdr_len)
                            write_enabled_out <= 1'b0;
                        else if (is_prog && len_ok && write_enabled_out)
                        begin
                            state <= ST_PROG;
                            busy_out <= 1'b1;
                            timer <= PROG_CYCLES[TW-1:0];
                            pend_op <= op;
                            pend_all <= (op == `SPG_OP_SPECIAL);
                            pend_addr <= org_s ? addr[ADDR_X16-1:0] : addr[ADDR_X8-1:1];
                            // Whole-array commands cover both byte lanes whatever the dummy address
                            pend_lo <= org_s | ~addr[0] | (op == `SPG_OP_SPECIAL);
                            pend_hi <= org_s | addr[0] | (op == `SPG_OP_SPECIAL);
                            pend_data <= has_data ?
                                (org_s ? wdata : {wdata[7:0], wdata[7:0]}) : 16'hffff;
                        end
                    end
                end
                ST_PROG:
                begin
                    // Only select is used here, to enable the status output; no shifting and no decoding
                    data_oe_out <= sel_s;
                    data_out <= 1'b0;
                    if (timer > 1)
                        timer <= timer - 1'b1;
                    else
                    begin
                        state <= ST_READY;
                        busy_out <= 1'b0;
                        // Ready level must appear together with the fall of busy
                        data_out <= 1'b1;
                        for (i = 0; i < WORDS; i = i + 1)
                        begin
                            if (pend_all || i == pend_addr)
                            begin
                                if (pend_lo)
                                    mem[i][7:0] <= pend_data[7:0];
                                if (pend_hi)
                                    mem[i][15:8] <= pend_data[15:8];
                            end
                        end
                    end
                end
                ST_READY:
                begin
                    data_oe_out <= sel_s;
                    data_out <= 1'b1;
                    // Ready ends at any select fall, even of a select that rose during programming, or at a start bit
                    if (sel_fall)
                        state <= ST_IDLE;
                    else if (rise && din_s)
                    begin
                        state <= ST_SHIFT;
                        data_oe_out <= 1'b0;
                        pulses <= {{(CW-1){1'b0}}, 1'b1};
                        shreg <= {SR{1'b0}};
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Array starts blank; reset does not touch it, as in nonvolatile storage
    initial
    begin
        for (j = 0; j < WORDS; j = j + 1)
            mem[j] = {16{`SPG_BLANK_BIT}};
    end
endmodule

// ===== spg_guard_asserts.sv
`timescale 1ns/100ps
module spg_guard_chk #(
    parameter PROG_CYCLES = 20
) (
    // Clock and reset
    input wire sys_clk_in,
    input wire rst_n_in,
    // Link from the host
    input wire sel_in,
    input wire link_clk_in,
    input wire data_in,
    input wire org_x16_in,
    // Outputs watched
    input wire data_out,
    input wire data_oe_out,
    input wire busy_out,
    input wire write_enabled_out
);
    int busy_len;
    always @(posedge sys_clk_in or negedge rst_n_in)
        if (!rst_n_in)
            busy_len <= 0;
        else
            busy_len <= busy_out ? busy_len + 1 : 0;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_sel_busy; (sel_in && busy_out) [*6]; endsequence
    sequence s_sel_idle; (!sel_in) [*6]; endsequence
    property p_busy_low; busy_out && data_oe_out |-> !data_out; endproperty
    a_busy_low: assert property (p_busy_low) else $error("busy level wrong");
    property p_ready_high; !busy_out && data_oe_out |-> data_out; endproperty
    a_ready_high: assert property (p_ready_high) else $error("ready level wrong");
    property p_busy_drive; s_sel_busy |-> data_oe_out; endproperty
    a_busy_drive: assert property (p_busy_drive) else $error("status not driven");
    property p_release; s_sel_idle |-> !data_oe_out; endproperty
    a_release: assert property (p_release) else $error("output not released");
    property p_busy_len; $fell(busy_out) |-> busy_len >= PROG_CYCLES && busy_len <= PROG_CYCLES + 1; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_judge; $rose(busy_out) |-> !$past(sel_in, 2); endproperty
    a_judge: assert property (p_judge) else $error("busy before select fell");
    property p_latch; $rose(busy_out) |-> write_enabled_out; endproperty
    a_latch: assert property (p_latch) else $error("busy with latch off");
    property p_hold; busy_out |=> $stable(write_enabled_out); endproperty
    a_hold: assert property (p_hold) else $error("input taken while busy");
endmodule

// ===== spg_host.sv
`timescale 1ns/100ps
module spg_host;
    // Separate in and out pins, so no shared wire to contend on
    logic sel_out = 0;
    logic lclk_out = 0;
    logic data_out = 0;
    task automatic frame(input logic [31:0] bits, input int n);
        sel_out = 1;
        for (int i = n - 1; i >= 0; i--)
        begin
            data_out = bits[i];
            #40 lclk_out = 1;
            #40 lclk_out = 0;
        end
        // Released line shows the inverse, not a stale bit
        data_out = ~data_out;
        #40 sel_out = 0;
        #60;
    endtask
    task automatic show(input int ns);
        sel_out = 1;
        #ns sel_out = 0;
        #100;
    endtask
endmodule

// ===== spg_regs.vh
`ifndef SPG_REGS_VH
`define SPG_REGS_VH

// Opcodes following the start bit
`define SPG_OP_SPECIAL 2'b00
`define SPG_OP_WRITE 2'b01
`define SPG_OP_READ 2'b10
`define SPG_OP_ERASE 2'b11

// Top two address bits of a special command
`define SPG_SUB_DISABLE 2'b00
`define SPG_SUB_FILL 2'b01
`define SPG_SUB_CLEAR 2'b10
`define SPG_SUB_ENABLE 2'b11

// Frame field lengths in link clock pulses
`define SPG_START_BITS 1
`define SPG_OPCODE_BITS 2
`define SPG_DATA_X8 8
`define SPG_DATA_X16 16

// Self-timed programming time
`define SPG_PROG_TIME_NS 5000000
`define SPG_CLK_PERIOD_NS 10

// Blank cell value
`define SPG_BLANK_BIT 1'b1

`endif

// ===== spg_sync.v
`timescale 1ns/100ps
module spg_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire sys_clk_in,
    input wire rst_n_in,
    // Asynchronous levels and their synchronised copies
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage;

    always @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            stage <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end
        else
        begin
            stage <= async_in;
            sync_out <= stage;
        end
    end
endmodule

// ===== tb_serial_eeprom_program_guard.sv
`timescale 1ns/100ps
module tb_serial_eeprom_program_guard;
    localparam PROG_CYCLES = 200;
    logic clk = 0, rst_n = 0, org = 0;
    wire dout, doe, busy, we;
    int err_total = 0, num_checks = 0;
    logic q[$];
    event tick;
    int tn[13] = '{12, 20, 19, 21, 20, 12, 12, 27, 26, 27, 11, 11, 27};
    int tl[13] = '{5, 3, 3, 3, 5, 5, 3, 3, 3, 5, 5, 5, 3};
    int tp[13] = '{19, 5, 5, 5, 17, 18, 7, 5, 5, 17, 18, 16, 5};
    logic te[13] = '{0, 1, 0, 0, 1, 1, 1, 1, 0, 1, 1, 0, 0};
    logic to[13] = '{0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1};
    spg_host host_u();
    spg_guard #(.PROG_CYCLES(PROG_CYCLES)) dut_u (.sys_clk_in(clk), .rst_n_in(rst_n), .sel_in(host_u.sel_out),
        .link_clk_in(host_u.lclk_out), .data_in(host_u.data_out), .org_x16_in(org), .data_out(dout),
        .data_oe_out(doe), .busy_out(busy), .write_enabled_out(we));
    initial forever #5 clk = ~clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(tick)
        chk({1'b0, busy}, {1'b0, q.pop_front()});
    task automatic prog;
        int i;
        // A disable frame sent while busy must not reach the latch
        fork
            host_u.frame(32'h800, 12);
            begin #150 chk({doe, dout}, 2'b10); end
        join
        chk({1'b0, we}, 2'b01);
        i = 0;
        while (busy !== 1'b0 && i < 500)
        begin
            @(posedge clk);
            i++;
        end
        #1 chk({15'b0, busy}, 16'h0000);
        fork
            host_u.show(300);
            begin #150 chk({doe, dout}, 2'b11); end
        join
        chk({doe, 1'b0}, 2'b00);
    endtask
    initial
    begin
        logic [31:0] bits;
        void'($urandom(32'hb039));
        repeat (4) @(posedge clk);
        #1 rst_n = 1;
        repeat (4) @(posedge clk);
        for (int k = 0; k < 13; k++)
        begin
            @(posedge clk);
            #1 org = to[k];
            // Fields after the fixed prefix are random, address of fill and clear included
            bits = (tp[k] << (tn[k] - tl[k])) | ($urandom & ((32'h1 << (tn[k] - tl[k])) - 1));
            host_u.frame(bits, tn[k]);
            q.push_back(te[k]);
            repeat (8) @(posedge clk);
            #1 ->tick;
            if (k == 0)
            begin
                chk({1'b0, we}, 2'b01);
                chk(dut_u.mem[0], 16'hffff);
            end
            if (te[k])
                prog();
            if (k == 4)
                chk(dut_u.mem[255], {bits[7:0], bits[7:0]});
            if (k == 5 || k == 10)
                chk(dut_u.mem[0] & dut_u.mem[255], 16'hffff);
            if (k == 7)
                chk(dut_u.mem[bits[23:16]], bits[15:0]);
            if (k == 9)
                chk(dut_u.mem[0], bits[15:0]);
            $display("test %0d done", k);
        end
        final_report();
    end
    initial
    begin
        #300000 err_total++;
        final_report();
    end
endmodule
bind spg_guard spg_guard_chk #(.PROG_CYCLES(PROG_CYCLES)) chk_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .sel_in(sel_in), .link_clk_in(link_clk_in), .data_in(data_in), .org_x16_in(org_x16_in), .data_out(data_out),
    .data_oe_out(data_oe_out), .busy_out(busy_out), .write_enabled_out(write_enabled_out));
